// >>> hw/nvsc_defines.vh
// nvsc_defines.vh: constants for the nonvolatile static memory host controller
// assumes a 20 MHz clock (50 ns period); included by its bare name
`ifndef NVSC_DEFINES_VH
`define NVSC_DEFINES_VH

// ------------------------------------------------------------
// clock and timing figures
// ------------------------------------------------------------
`define NVSC_CLK_PERIOD_NS      50
`define NVSC_WRITE_GRACE_NS     25
`define NVSC_HW_STORE_PULSE_NS  15
`define NVSC_BUSY_DRIVE_NS      500
`define NVSC_POWERUP_BUSY_US    5
`define NVSC_SOFT_SEQ_US        100
`define NVSC_RECALL_MS          20
`define NVSC_ACCESS_NS          25
// least times round up, none below one cycle
`define NVSC_CEIL_CYC(ns) (((ns) + `NVSC_CLK_PERIOD_NS - 1) / `NVSC_CLK_PERIOD_NS)
`define NVSC_HW_PULSE_CYC  ((`NVSC_CEIL_CYC(`NVSC_HW_STORE_PULSE_NS) < 1) ? 1 : \
	`NVSC_CEIL_CYC(`NVSC_HW_STORE_PULSE_NS))
`define NVSC_ACCESS_CYC    ((`NVSC_CEIL_CYC(`NVSC_ACCESS_NS) < 1) ? 1 : \
	`NVSC_CEIL_CYC(`NVSC_ACCESS_NS))
`define NVSC_GRACE_CYC     ((`NVSC_CEIL_CYC(`NVSC_WRITE_GRACE_NS) < 1) ? 1 : \
	`NVSC_CEIL_CYC(`NVSC_WRITE_GRACE_NS))
`define NVSC_SOFT_SEQ_CYC  (`NVSC_SOFT_SEQ_US * 1000 / `NVSC_CLK_PERIOD_NS)
`define NVSC_RECALL_CYC    (`NVSC_RECALL_MS * 1000000 / `NVSC_CLK_PERIOD_NS)
`define NVSC_PWRUP_CYC     (`NVSC_POWERUP_BUSY_US * 1000 / `NVSC_CLK_PERIOD_NS)
// settle waits after requests and between soft sequence reads, in cycles
`define NVSC_WAIT_CYC      2
`define NVSC_HWST_WAIT_CYC 4
`define NVSC_GAP_CYC       1

// ------------------------------------------------------------
// command encodings and widths
// ------------------------------------------------------------
`define NVSC_ADDR_W        15
`define NVSC_DATA_W        8
`define NVSC_CMD_READ      2'h0
`define NVSC_CMD_WRITE     2'h1
`define NVSC_CMD_SOFT      2'h2
`define NVSC_CMD_HWSTORE   2'h3
`define NVSC_SEQ_LEN       6

`endif

// >>> hw/nvsc_timer.v
// nvsc_timer.v: loadable down counter used for every wait of the controller
// assumes load and counting on the one system clock
`timescale 1ns/1ns
module nvsc_timer #(
	parameter W = 20
) (
	input  wire         clk_i,
	input  wire         rstn_i,
	input  wire         load_i,
	input  wire [W-1:0] count_i,
	output wire         done_o
);
	reg [W-1:0] cnt;

	// ------------------------------------------------------------
	// counter
	// ------------------------------------------------------------
	// reload has priority so a new wait never inherits stale time
	always @(posedge clk_i)
	begin
		if (!rstn_i)
			cnt <= {W{1'b0}};
		else if (load_i)
			cnt <= count_i;
		else if (cnt != {W{1'b0}})
			cnt <= cnt - {{(W-1){1'b0}}, 1'b1};
	end

	assign done_o = (cnt == {W{1'b0}}) & ~load_i;
endmodule

// >>> hw/nvsc_host.v
// nvsc_host.v: host controller driving a nonvolatile-shadowed static memory
// assumes the memory pins are wired straight out; busy line is open drain
// with an external pull-up, and the data bus is resolved by the testbench
`timescale 1ns/1ns
`include "nvsc_defines.vh"
module nvsc_host #(
	parameter AW          = `NVSC_ADDR_W,
	parameter DW          = `NVSC_DATA_W,
	parameter TW          = 20,
	parameter RECALL_CYC  = `NVSC_RECALL_CYC,
	parameter SOFT_CYC    = `NVSC_SOFT_SEQ_CYC,
	parameter PWRUP_CYC   = `NVSC_PWRUP_CYC,
	parameter [AW-1:0] SEQ_A0 = 15'h0e38,
	parameter [AW-1:0] SEQ_A1 = 15'h31c7,
	parameter [AW-1:0] SEQ_A2 = 15'h03e0,
	parameter [AW-1:0] SEQ_A3 = 15'h3c1f,
	parameter [AW-1:0] SEQ_A4 = 15'h303f,
	parameter [AW-1:0] SEQ_A5 = 15'h0fc0
) (
	input  wire          clk_i,
	input  wire          rstn_i,
	// user command port
	input  wire          req_valid_i,
	output wire          req_ready_o,
	input  wire [1:0]    req_cmd_i,
	input  wire [AW-1:0] req_addr_i,
	input  wire [DW-1:0] req_wdata_i,
	input  wire [AW-1:0] req_last_addr_i,
	output reg           rsp_valid_o,
	output reg  [DW-1:0] rsp_rdata_o,
	output reg           busy_o,
	// memory pins
	output reg           mem_ce_n_o,
	output reg           mem_we_n_o,
	output reg           mem_oe_n_o,
	output reg  [AW-1:0] mem_addr_o,
	input  wire [DW-1:0] mem_dq_i,
	output reg  [DW-1:0] mem_dq_o,
	output reg           mem_dq_oe_o,
	input  wire          hw_store_busy_n_i,
	output wire          hw_store_busy_n_o,
	output reg           hw_store_busy_n_oe_o
);
	// ------------------------------------------------------------
	// states
	// ------------------------------------------------------------
	localparam [6:0] S_PWRUP = 7'h01;
	localparam [6:0] S_IDLE  = 7'h02;
	localparam [6:0] S_RD    = 7'h04;
	localparam [6:0] S_WR    = 7'h08;
	localparam [6:0] S_SEQ   = 7'h10;
	localparam [6:0] S_HWST  = 7'h20;
	localparam [6:0] S_WAIT  = 7'h40;

	// timer loads held at the timer's own width
	localparam [TW-1:0] ACCESS_CNT = `NVSC_ACCESS_CYC;
	localparam [TW-1:0] PULSE_CNT  = `NVSC_HW_PULSE_CYC;
	localparam [TW-1:0] WAIT_CNT   = `NVSC_WAIT_CYC;
	localparam [TW-1:0] HWST_CNT   = `NVSC_HWST_WAIT_CYC;
	localparam [TW-1:0] GAP_CNT    = `NVSC_GAP_CYC;
	localparam [2:0]    LAST_IDX   = `NVSC_SEQ_LEN - 1;

	reg  [6:0]    state;
	reg  [2:0]    seq_idx;
	reg           soft_mode;
	reg  [AW-1:0] soft_last;
	reg           busy_s1;
	reg           busy_s2;
	reg  [DW-1:0] dq_s1;
	reg  [DW-1:0] dq_s2;
	reg           tmr_load;
	reg  [TW-1:0] tmr_count;
	wire          tmr_done;

	// sequence address lookup; the last one selects the command
	function [AW-1:0] seq_addr;
		input [2:0]    idx;
		input [AW-1:0] last;
		begin
			case (idx)
				3'h0:    seq_addr = SEQ_A0;
				3'h1:    seq_addr = SEQ_A1;
				3'h2:    seq_addr = SEQ_A2;
				3'h3:    seq_addr = SEQ_A3;
				3'h4:    seq_addr = SEQ_A4;
				default: seq_addr = last;
			endcase
		end
	endfunction

	nvsc_timer #(.W(TW)) u_timer (
		.clk_i   (clk_i),
		.rstn_i  (rstn_i),
		.load_i  (tmr_load),
		.count_i (tmr_count),
		.done_o  (tmr_done)
	);

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	// busy and read data come from outside, two stages before use
	always @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			busy_s1 <= 1'b1;
			busy_s2 <= 1'b1;
			dq_s1   <= {DW{1'b0}};
			dq_s2   <= {DW{1'b0}};
		end
		else
		begin
			busy_s1 <= hw_store_busy_n_i;
			busy_s2 <= busy_s1;
			dq_s1   <= mem_dq_i;
			dq_s2   <= dq_s1;
		end
	end

	// open drain: only ever pulls low
	assign hw_store_busy_n_o = 1'b0;
	// device busy low blocks new accesses
	assign req_ready_o = (state == S_IDLE) & busy_s2;

	// ------------------------------------------------------------
	// main sequencer
	// ------------------------------------------------------------
	always @(posedge clk_i)
	begin
		tmr_load  <= 1'b0;
		tmr_count <= {TW{1'b0}};
		if (!rstn_i)
		begin
			state                <= S_PWRUP;
			seq_idx              <= 3'h0;
			soft_mode            <= 1'b0;
			soft_last            <= {AW{1'b0}};
			rsp_valid_o          <= 1'b0;
			rsp_rdata_o          <= {DW{1'b0}};
			busy_o               <= 1'b1;
			mem_ce_n_o           <= 1'b1;
			mem_we_n_o           <= 1'b1;
			mem_oe_n_o           <= 1'b1;
			mem_addr_o           <= {AW{1'b0}};
			mem_dq_o             <= {DW{1'b0}};
			mem_dq_oe_o          <= 1'b0;
			hw_store_busy_n_oe_o <= 1'b0;
			tmr_load             <= 1'b1;
			tmr_count            <= RECALL_CYC[TW-1:0];
		end
		else
		begin
			rsp_valid_o <= 1'b0;
			case (state)
				// power-up recall window; then wait for busy released
				S_PWRUP:
				begin
					if (tmr_done && busy_s2)
					begin
						state  <= S_IDLE;
						busy_o <= 1'b0;
					end
				end
				S_IDLE:
				begin
					if (req_valid_i && busy_s2)
					begin
						busy_o     <= 1'b1;
						mem_addr_o <= req_addr_i;
						tmr_load   <= 1'b1;
						tmr_count  <= ACCESS_CNT;
						case (req_cmd_i)
							`NVSC_CMD_WRITE:
							begin
								// write enable falls a cycle before chip enable
								state       <= S_WR;
								mem_we_n_o  <= 1'b0;
								mem_dq_o    <= req_wdata_i;
								mem_dq_oe_o <= 1'b1;
							end
							`NVSC_CMD_SOFT:
							begin
								// chip-enable framed reads
								state      <= S_SEQ;
								soft_mode  <= 1'b1;
								soft_last  <= req_last_addr_i;
								seq_idx    <= 3'h0;
								mem_addr_o <= SEQ_A0;
								mem_ce_n_o <= 1'b0;
								mem_oe_n_o <= 1'b0;
							end
							`NVSC_CMD_HWSTORE:
							begin
								// pull busy low for the least pulse
								state                <= S_HWST;
								hw_store_busy_n_oe_o <= 1'b1;
								tmr_count            <= PULSE_CNT;
							end
							default:
							begin
								// read: write enable held high
								state      <= S_RD;
								mem_ce_n_o <= 1'b0;
								mem_oe_n_o <= 1'b0;
							end
						endcase
					end
				end
				S_RD:
				begin
					if (tmr_done)
					begin
						state       <= S_WAIT;
						mem_ce_n_o  <= 1'b1;
						mem_oe_n_o  <= 1'b1;
						rsp_valid_o <= 1'b1;
						rsp_rdata_o <= dq_s2;
						tmr_load    <= 1'b1;
						tmr_count   <= WAIT_CNT;
					end
				end
				S_WR:
				begin
					// the grace window covers the write's own end
					if (tmr_done)
					begin
						// data stays driven a cycle past the write's end
						state       <= S_WAIT;
						mem_ce_n_o  <= 1'b1;
						mem_we_n_o  <= 1'b1;
						rsp_valid_o <= 1'b1;
						tmr_load    <= 1'b1;
						tmr_count   <= WAIT_CNT;
					end
					else
						mem_ce_n_o <= 1'b0;
				end
				S_SEQ:
				begin
					if (tmr_done)
					begin
						mem_ce_n_o <= 1'b1;
						mem_oe_n_o <= 1'b1;
						if (seq_idx == LAST_IDX)
						begin
							// sixth read's data discarded
							state       <= S_WAIT;
							rsp_valid_o <= 1'b1;
							tmr_load    <= 1'b1;
							tmr_count   <= SOFT_CYC[TW-1:0];
						end
						else
						begin
							seq_idx    <= seq_idx + 3'h1;
							mem_addr_o <= seq_addr(seq_idx + 3'h1, soft_last);
							state      <= S_RD;
							tmr_load   <= 1'b1;
							tmr_count  <= GAP_CNT;
						end
					end
				end
				S_HWST:
				begin
					if (tmr_done)
					begin
						// release; device drives busy itself
						state                <= S_WAIT;
						hw_store_busy_n_oe_o <= 1'b0;
						rsp_valid_o          <= 1'b1;
						tmr_load             <= 1'b1;
						tmr_count            <= HWST_CNT;
					end
				end
				S_WAIT:
				begin
					mem_dq_oe_o <= 1'b0; // write data released after its hold
					// skipped store shows as busy never low
					if (tmr_done && busy_s2)
					begin
						state     <= S_IDLE;
						busy_o    <= 1'b0;
						soft_mode <= 1'b0;
					end
				end
				default:
				begin
					state <= S_IDLE;
				end
			endcase
			// gaps between soft sequence reads pass through S_RD one at a time
			if (state == S_RD && soft_mode && tmr_done)
			begin
				state       <= S_SEQ;
				rsp_valid_o <= 1'b0;
				mem_ce_n_o  <= 1'b0;
				mem_oe_n_o  <= 1'b0;
				tmr_load    <= 1'b1;
				tmr_count   <= ACCESS_CNT;
			end
		end
	end
endmodule

// >>> testbench/nvsc_host_checker.sv
// nvsc_host_checker.sv: pin and handshake assertions for the host controller
// assumes binding into nvsc_host, one clock, synchronous active-low reset
`timescale 1ns/1ns
module nvsc_host_checker (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic req_valid_i,
	input wire logic req_ready_o,
	input wire logic rsp_valid_o,
	input wire logic mem_ce_n_o,
	input wire logic mem_we_n_o,
	input wire logic mem_oe_n_o,
	input wire logic mem_dq_oe_o,
	input wire logic hw_store_busy_n_i,
	input wire logic hw_store_busy_n_o,
	input wire logic hw_store_busy_n_oe_o
);
	// all checks share the one clock and reset
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	AST_READ_WE_HIGH: assert property (!mem_ce_n_o && !mem_oe_n_o |-> mem_we_n_o)
		else $error("write enable low during read");
	AST_BUSY_FREE_IN_ACCESS: assert property (!mem_ce_n_o |-> !hw_store_busy_n_oe_o)
		else $error("busy pulled during access");
	AST_NO_DQ_ON_READ: assert property (!mem_oe_n_o |-> !mem_dq_oe_o)
		else $error("bus driven while device reads out");
	AST_PULL_IS_LOW: assert property (hw_store_busy_n_oe_o |-> !hw_store_busy_n_o)
		else $error("busy pin driven high");
	AST_PULL_ENDS: assert property ($rose(hw_store_busy_n_oe_o) |-> ##[1:4] !hw_store_busy_n_oe_o)
		else $error("store request pulse too long");
	AST_ANSWER_BOUNDED: assert property (req_valid_i && req_ready_o |-> ##[1:60] rsp_valid_o)
		else $error("request never answered");
	AST_READY_HELD_BUSY: assert property (!hw_store_busy_n_i [*3] |-> !req_ready_o)
		else $error("ready while device busy");
	// main scenarios reached
	cover property (!mem_ce_n_o && !mem_oe_n_o);
	cover property (!mem_ce_n_o && !mem_we_n_o);
	cover property ($rose(hw_store_busy_n_oe_o));
endmodule
bind nvsc_host nvsc_host_checker nvsc_host_checker_i (.*);

// >>> testbench/nvsc_mem_model.sv
// nvsc_mem_model.sv: behavioural nonvolatile-shadowed static memory
// assumes the bench resolves the data bus and the pulled-up busy line
`timescale 1ns/1ns
module nvsc_mem_model #(
	parameter OP_NS = 2000,
	parameter RC_NS = 1000
) (
	input  logic        ce_n_i,
	input  logic        we_n_i,
	input  logic        oe_n_i,
	input  logic [14:0] addr_i,
	input  logic [7:0]  dq_i,
	input  logic        busy_n_i,
	output logic [7:0]  dq_o,
	output logic        dq_oe_o,
	output logic        busy_low_o,
	output logic        busy_high_o
);
	localparam logic [14:0] STORE_A = 15'h0fc0;
	localparam logic [14:0] RECALL_A = 15'h0c63; // arbitrary command address
	logic [7:0]  sram [int];
	logic [7:0]  nv [int];
	logic [14:0] seq [5] = '{15'h0e38, 15'h31c7, 15'h03e0, 15'h3c1f, 15'h303f};
	logic [14:0] wa, sa;
	logic [7:0]  wd, rd, last = 8'h00;
	logic        dirty = 0, nv_busy = 1, locked = 1, we_at_ce = 0;
	int          step = 0;
	wire         wr_act = !ce_n_i && !we_n_i;
	wire         rd_act = !ce_n_i && we_n_i && !oe_n_i;
	// store or recall: busy low and no access served throughout
	task automatic nv_op(input logic store);
		nv_busy = 1;
		busy_low_o = 1;
		#OP_NS;
		if (store) nv = sram; else sram = nv;
		dirty &= !store;
		finish_op();
	endtask
	// brief high drive then release, just below the limit
	task automatic finish_op();
		busy_low_o = 0;
		busy_high_o = 1;
		nv_busy = 0;
		fork #400 busy_high_o = 0; join_none
	endtask
	// power-up recall: busy driven from time zero
	initial
	begin
		busy_low_o = 1;
		busy_high_o = 0;
		#RC_NS finish_op();
	end
	// writes finishing inside the grace time still land
	always @(nv_busy) locked <= #25 nv_busy;
	always @(ce_n_i) we_at_ce = !ce_n_i && !we_n_i;
	always @* if (wr_act) {wa, wd} = {addr_i, dq_i};
	always @* if (rd_act) sa = addr_i;
	always @(addr_i or dq_oe_o) rd = sram.exists(addr_i) ? sram[addr_i] : last;
	// released bus shows the inverse, never a stale match
	assign dq_oe_o = rd_act && !nv_busy && !we_at_ce;
	assign dq_o = dq_oe_o ? rd : ~last;
	always @(negedge dq_oe_o) last = rd;
	always @(negedge wr_act)
		if (!locked)
		begin
			sram[wa] = wd;
			dirty = 1;
		end
	// each read end clocks the sequence; sixth address picks the command
	always @(negedge rd_act)
		if (!nv_busy)
		begin
			if (step == 5 && (sa == STORE_A || sa == RECALL_A))
			begin
				step = 0;
				nv_op(sa == STORE_A);
			end
			else step = (step < 5 && sa == seq[step]) ? step + 1 : int'(sa == seq[0]);
		end
	// hardware store request: skipped when nothing was written
	always @(negedge busy_n_i)
		if (!busy_low_o && !nv_busy && dirty) nv_op(1);
endmodule

// >>> testbench/nvsc_host_test.sv
// nvsc_host_test.sv: self-checking bench for the host controller
// assumes the memory model beside it and a pull-up on the busy line
`timescale 1ns/1ns
module nvsc_host_test;
	logic        clk_i = 0, rstn_i = 0, req_valid_i = 0;
	logic [1:0]  req_cmd_i = 0;
	logic [14:0] req_addr_i = 0, req_last_addr_i = 0;
	logic [7:0]  req_wdata_i = 0, rd;
	wire         req_ready_o, rsp_valid_o, busy_o, mem_ce_n_o, mem_we_n_o, mem_oe_n_o;
	wire         mem_dq_oe_o, hw_store_busy_n_o, hw_store_busy_n_oe_o, dev_oe, dev_low;
	wire [7:0]   rsp_rdata_o, mem_dq_o, mem_dq_i, dev_dq;
	wire [14:0]  mem_addr_o;
	wire         hw_store_busy_n_i = !(hw_store_busy_n_oe_o || dev_low);
	int          n_mismatch = 0, total_checks = 0, cyc = 0, low_cyc = 0;
	assign mem_dq_i = mem_dq_oe_o ? mem_dq_o : dev_dq;
	nvsc_host #(.RECALL_CYC(50), .SOFT_CYC(20)) nvsc_host_i (.*);
	nvsc_mem_model nvsc_mem_model_i (.ce_n_i(mem_ce_n_o), .we_n_i(mem_we_n_o),
		.oe_n_i(mem_oe_n_o), .addr_i(mem_addr_o), .dq_i(mem_dq_i),
		.busy_n_i(hw_store_busy_n_i), .dq_o(dev_dq), .dq_oe_o(dev_oe),
		.busy_low_o(dev_low), .busy_high_o());
	always #25 clk_i = ~clk_i;
	// cycle ceiling and busy-low counter
	always @(posedge clk_i)
	begin
		cyc++;
		if (!hw_store_busy_n_i) low_cyc++;
		if (cyc == 20000)
		begin
			n_mismatch++;
			$display("ERROR %0t: cycle limit reached", $time);
			end_sim();
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("ERROR %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// one request: wait ready, hold valid over the taking edge, wait answer
	task automatic req(input logic [1:0] c, input logic [14:0] a, input logic [7:0] d,
		input logic [14:0] l);
		int n;
		n = 0;
		{req_cmd_i, req_addr_i, req_wdata_i, req_last_addr_i} = {c, a, d, l};
		req_valid_i = 1;
		while (req_ready_o !== 1 && n < 4000)
		begin
			@(posedge clk_i) #2 n++;
		end
		@(posedge clk_i) #2 req_valid_i = 0;
		while (rsp_valid_o !== 1 && n < 4000)
		begin
			@(posedge clk_i) #2 n++;
		end
		rd = rsp_rdata_o;
		chk(n < 4000, 1);
	endtask
	// answer comes before the device lets go; wait for idle, bounded
	task automatic wait_idle();
		int n;
		n = 0;
		while (busy_o !== 0 && n < 4000)
		begin
			@(posedge clk_i) #2 n++;
		end
		chk(n < 4000, 1);
	endtask
	task automatic t_rw();
		logic [14:0] a [3] = '{15'h0000, 15'h7fff, 15'h1234};
		logic [7:0]  d [3] = '{8'h5a, 8'hc3, 8'h01};
		foreach (a[i]) req(1, a[i], d[i], 0);
		foreach (a[i])
		begin
			req(0, a[i], 0, 0);
			chk(rd, d[i]);
		end
	endtask
	task automatic t_nv();
		// earlier writes are pending, so this store really runs
		low_cyc = 0;
		req(3, 0, 0, 0);
		wait_idle();
		chk(low_cyc > 20, 1);
		// nothing written since: only our own pulse holds the line low
		low_cyc = 0;
		req(3, 0, 0, 0);
		wait_idle();
		chk(low_cyc < 4, 1);
		req(1, 15'h0042, 8'h96, 0);
		low_cyc = 0;
		req(3, 0, 0, 0);
		wait_idle();
		chk(low_cyc > 20, 1);
		req(1, 15'h0042, 8'h3c, 0);
		req(2, 0, 0, 15'h0c63);
		req(0, 15'h0042, 0, 0);
		chk(rd, 8'h96);
		req(1, 15'h0042, 8'h3c, 0);
		req(2, 0, 0, 15'h0fc0);
		req(1, 15'h0042, 8'h00, 0);
		req(2, 0, 0, 15'h0c63);
		req(0, 15'h0042, 0, 0);
		chk(rd, 8'h3c);
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		repeat (3) @(posedge clk_i);
		#2 rstn_i = 1;
		chk(busy_o, 1);
		t_rw();
		t_nv();
		end_sim();
	end
endmodule
